// ===== hdl/acc_pkg.sv
package acc_pkg;
  localparam int NCONV = 2;
  localparam int RES_W = 10;
  localparam logic [3:0] RES_LAST = 4'(RES_W - 1);

  localparam logic [7:0] A_CTL_A = 8'h00;
  localparam logic [7:0] A_CTL_B = 8'h04;
  localparam logic [7:0] A_COM   = 8'h08;
  localparam logic [7:0] A_TRIG  = 8'h0C;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam logic [7:0] A_RES   = 8'h14;
  localparam logic [7:0] A_RES_E = 8'h20;

  localparam int B_EN   = 0;
  localparam int B_GO   = 1;
  localparam int CH_LO  = 2;
  localparam int CH_HI  = 6;
  localparam int B_GALL = 0;
  localparam int B_DSE  = 1;
  localparam int B_RC   = 2;
  localparam int B_IE   = 3;
  localparam int TS_LO  = 4;
  localparam int TS_HI  = 6;

  localparam logic [2:0] TS_NONE = 3'h0;
  localparam logic [2:0] TS_T0   = 3'h3;
  localparam logic [2:0] TS_T1   = 3'h4;
  localparam logic [2:0] TS_T2   = 3'h5;
  localparam logic [2:0] TS_RISE = 3'h6;
  localparam logic [2:0] TS_FALL = 3'h7;

  localparam logic [4:0] CH_LOW_END = 5'h02;
  localparam logic [4:0] CH_HI_BEG  = 5'h14;
  localparam logic [4:0] CH_HI_END  = 5'h1A;
  localparam logic [4:0] CH_POSITIVE_REFERENCE   = 5'h1B;
  localparam logic [4:0] CH_TEMP    = 5'h1D;
  localparam logic [4:0] CH_FVR     = 5'h1F;

  localparam logic [2:0] SYS_DIV = 3'h1;
  localparam logic [2:0] RC_DIV  = 3'h3;
  localparam int INST_NS  = 100;
  localparam int CLK_NS   = 100;
  localparam logic [1:0] RC_WAIT = 2'((INST_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} acc_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } acc_apb_req_s;

  function automatic logic acc_ch_ok(input logic [4:0] c);
    acc_ch_ok = (c <= CH_LOW_END) || (c >= CH_HI_BEG && c <= CH_HI_END)
             || c == CH_POSITIVE_REFERENCE || c == CH_TEMP || c == CH_FVR;
  endfunction : acc_ch_ok

  function automatic logic [RES_W-1:0] acc_fill(input logic [RES_W-1:0] s,
                                                input logic [3:0] n);
    logic [RES_W-1:0] r;
    logic             lb;
    r  = s;
    lb = (n == 4'h0) ? 1'b0 : s[RES_W - int'(n)];
    for (int k = 0; k < RES_W; k++)
      if (k < RES_W - int'(n))
        r[k] = lb;
    acc_fill = r;
  endfunction : acc_fill
endpackage : acc_pkg

// ===== hdl/acc_top.sv
module acc_top
  import acc_pkg::*;
(
  input  wire  logic                              ref_clk,
  input  wire  logic                              rst_n,
  input  wire  acc_pkg::acc_apb_req_s             apb_req,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire  logic [acc_pkg::NCONV-1:0]         cmp_bit,
  input  wire  logic                              sleep_req,
  input  wire  logic                              tmr0_ovf,
  input  wire  logic                              tmr1_ovf,
  input  wire  logic                              tmr2_match,
  input  wire  logic                              external_trigger_pin,
  output logic [acc_pkg::NCONV-1:0]               conv_power,
  output logic [acc_pkg::NCONV-1:0]               ch_connect,
  output logic [acc_pkg::NCONV-1:0][4:0]          ch_route,
  output logic [acc_pkg::NCONV-1:0]               sample_go,
  output logic                                    wake
);
  import acc_pkg::*;

  logic [NCONV-1:0]          en;
  logic [NCONV-1:0][4:0]     ch;
  logic                      go_all;
  logic                      dse;
  logic                      rc_sel;
  logic                      ie;
  logic [2:0]                tsel;
  logic [NCONV-1:0]          go;
  logic [NCONV-1:0]          done;
  logic [NCONV-1:0]          sync;
  logic [NCONV-1:0]          last;
  logic [NCONV-1:0]          pwr_off;
  logic [RES_W-1:0]          res [2*NCONV];
  logic [2:0]                div;
  logic                      tick;
  logic [2:0]                ext_ff;
  logic                      ext_lvl;
  logic                      trig_src;
  logic                      trig_q;
  logic                      trig_edge;
  logic                      wr;
  logic                      mapped;
  logic [NCONV-1:0]          wr_ctl;
  logic                      wr_com;
  logic [31:0]               wd;
  logic [31:0]               next_rdata;

  assign wr     = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign wd     = apb_req.pwdata;
  assign wr_ctl = {wr & (apb_req.paddr == A_CTL_B), wr & (apb_req.paddr == A_CTL_A)};
  assign wr_com = wr & (apb_req.paddr == A_COM);
  assign mapped = (apb_req.paddr <= A_RES_E) && (apb_req.paddr[1:0] == 2'h0);
  // Zero wait states keep the core's register timing
  assign pready  = 1'b1;
  assign pslverr = apb_req.psel & apb_req.penable & ~mapped;

  always_comb
  begin
    next_rdata = 32'h0;
    case (apb_req.paddr)
      A_CTL_A: next_rdata = {25'h0, ch[0], go[0], en[0]};
      A_CTL_B: next_rdata = {25'h0, ch[1], go[1], en[1]};
      A_COM:   next_rdata = {28'h0, ie, rc_sel, dse, go_all};
      A_TRIG:  next_rdata = {25'h0, tsel, 4'h0};
      A_STAT:  next_rdata = {30'h0, done};
      default:
      begin
        if (mapped && apb_req.paddr >= A_RES)
          next_rdata = {22'h0, res[2'(apb_req.paddr[4:2] - A_RES[4:2])]};
      end
    endcase
  end

  // Read data prepared in the setup phase
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
      prdata <= next_rdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      en     <= '0;
      ch     <= '0;
      dse    <= 1'b0;
      rc_sel <= 1'b0;
      ie     <= 1'b0;
      tsel   <= TS_NONE;
    end
    else
    begin
      for (int i = 0; i < NCONV; i++)
        if (wr_ctl[i])
        begin
          en[i] <= wd[B_EN];
          ch[i] <= wd[CH_HI:CH_LO];
        end
      if (wr_com)
      begin
        dse    <= wd[B_DSE];
        rc_sel <= wd[B_RC];
        ie     <= wd[B_IE];
      end
      if (wr && apb_req.paddr == A_TRIG)
        tsel <= wd[TS_HI:TS_LO];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      go_all <= 1'b0;
    else if (wr_com)
      go_all <= wd[B_GALL] & (|en);
    else if (go_all && sync == '0)
      go_all <= 1'b0;
  end

  // Conversion clock enable; RC rate is slower
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      div <= 3'h0;
    else if (tick)
      div <= 3'h0;
    else
      div <= div + 3'h1;
  end
  assign tick = div >= (rc_sel ? RC_DIV : SYS_DIV);

  // Pin crosses three stages; level moves on agreement
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ext_ff  <= 3'h0;
      ext_lvl <= 1'b0;
    end
    else
    begin
      ext_ff <= {ext_ff[1:0], external_trigger_pin};
      if (ext_ff[1] == ext_ff[2])
        ext_lvl <= ext_ff[2];
    end
  end

  always_comb
  begin
    case (tsel)
      TS_T0:   trig_src = tmr0_ovf;
      TS_T1:   trig_src = tmr1_ovf;
      TS_T2:   trig_src = tmr2_match;
      TS_RISE: trig_src = ext_lvl;
      TS_FALL: trig_src = ~ext_lvl;
      default: trig_src = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      trig_q <= 1'b0;
    else
      trig_q <= trig_src;
  end
  assign trig_edge = trig_src & ~trig_q;

  for (genvar i = 0; i < NCONV; i++)
  begin : g_cv
    acc_state_e       st;
    logic             go_q;
    logic             half;
    logic [1:0]       wcnt;
    logic [3:0]       n;
    logic [RES_W-1:0] sar;
    logic [RES_W-1:0] next_sar;
    logic             start_sw;
    logic             start_hw;
    logic             start;
    logic             stop_sw;
    logic             fin;
    logic             abort;
    logic [RES_W-1:0] pair [2];

    assign start_sw = (wr_ctl[i] & wd[B_GO] & en[i] & wd[B_EN])
                    | (wr_com & wd[B_GALL] & ~go_all & en[i]);
    assign start_hw = trig_edge & en[i] & ~go_q;
    assign start    = ~go_q & (start_sw | start_hw);
    assign stop_sw  = go_q & ((wr_ctl[i] & ~wd[B_GO])
                    | (wr_com & ~wd[B_GALL] & sync[i]));
    assign fin      = st == ST_CONV && tick && n == RES_LAST;
    assign last[i]  = fin & (~dse | half);
    assign abort    = go_q & ((sleep_req & ~rc_sel) | ~en[i]);
    assign go[i]    = go_q;

    always_comb
    begin
      next_sar = sar;
      next_sar[RES_LAST - n] = cmp_bit[i];
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        st   <= ST_IDLE;
        go_q <= 1'b0;
        half <= 1'b0;
        wcnt <= 2'h0;
        n    <= 4'h0;
        sar  <= '0;
      end
      else if (abort || stop_sw || last[i])
      begin
        st   <= ST_IDLE;
        go_q <= 1'b0;
      end
      else if (start)
      begin
        go_q <= 1'b1;
        half <= 1'b0;
        n    <= 4'h0;
        sar  <= '0;
        wcnt <= RC_WAIT;
        st   <= rc_sel ? ST_WAIT : ST_CONV;
      end
      else if (st == ST_WAIT)
      begin
        wcnt <= wcnt - 2'h1;
        if (wcnt == 2'h1)
          st <= ST_CONV;
      end
      else if (st == ST_CONV && tick)
      begin
        sar <= next_sar;
        n   <= n + 4'h1;
        if (fin)
        begin
          half <= 1'b1;
          n    <= 4'h0;
        end
      end
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        sync[i] <= 1'b0;
      else if (abort || stop_sw || last[i])
        sync[i] <= 1'b0;
      else if (start && wr_com && wd[B_GALL])
        sync[i] <= 1'b1;
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
      begin
        pair[0] <= '0;
        pair[1] <= '0;
      end
      else if (stop_sw && st == ST_CONV)
        pair[half] <= acc_fill(sar, n);
      else if (fin)
        pair[half] <= next_sar;
    end
    // Local pair keeps one writer per converter
    assign res[2*i]   = pair[0];
    assign res[2*i+1] = pair[1];

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        done[i] <= 1'b0;
      else if (last[i])
        done[i] <= 1'b1;
      else if (wr && apb_req.paddr == A_STAT && wd[i])
        done[i] <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
      if (!rst_n)
        pwr_off[i] <= 1'b0;
      else if (!sleep_req)
        pwr_off[i] <= 1'b0;
      else if ((last[i] && rc_sel && !ie) || abort)
        pwr_off[i] <= 1'b1;
    end

    // power and mux gated by enable
    assign conv_power[i] = en[i] & ~pwr_off[i];
    assign ch_connect[i] = conv_power[i] & acc_ch_ok(ch[i]);
    assign ch_route[i]   = ch[i];
    assign sample_go[i]  = st == ST_CONV;

    chk_go_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      last[i] |=> !go[i] && done[i])
      else $error("go not cleared or flag not set at completion");
    chk_abort_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stop_sw && !done[i]) |=> !done[i])
      else $error("software stop set done flag");
    chk_off_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (!en[i] && !(wr_ctl[i] && wd[B_EN])) |=> !go[i] && !ch_connect[i])
      else $error("disabled converter busy or connected");
    chk_trig_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (start_hw && !abort) |=> go[i])
      else $error("trigger edge did not set go");
    chk_rc_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (start && rc_sel && !abort && !stop_sw) |=> st == ST_WAIT ##1 (st == ST_CONV || !go[i]))
      else $error("RC start did not wait");
    chk_sleep_abort: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (go[i] && sleep_req && !rc_sel && en[i]) |=> !go[i] && !conv_power[i])
      else $error("sleep did not abort conversion");
    chk_single_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (fin && !dse && !half) |=> $stable(res[2*i+1]))
      else $error("single sample touched second pair");
    chk_partial: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (stop_sw && st == ST_CONV && n == 4'h1) |=> res[2*i + int'(half)] == {RES_W{sar[RES_LAST]}})
      else $error("partial result not filled");
  end

  assign wake = sleep_req & ie & rc_sel & (|last);

  chk_sync_both: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_com && wd[B_GALL] && !go_all && (&en) && go == '0 && !sleep_req) |=> (&go) && go_all)
    else $error("go-all did not start both converters");
endmodule : acc_top

// ===== tb/acc_far.sv
module acc_far
  import acc_pkg::*;
(
  input  wire logic                      ref_clk,
  input  wire logic [acc_pkg::NCONV-1:0] level,
  input  wire logic [acc_pkg::NCONV-1:0] powered,
  input  wire logic [2:0]                fire_sel,
  input  wire logic                      fire,
  output logic [acc_pkg::NCONV-1:0]      cmp_bit,
  output logic                           tmr0_ovf,
  output logic                           tmr1_ovf,
  output logic                           tmr2_match,
  output logic                           ext_pin
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    cmp_bit = '0;
    tmr0_ovf = 1'b0;
    tmr1_ovf = 1'b0;
    tmr2_match = 1'b0;
    ext_pin = 1'b0;
  end

  // Unpowered comparator wanders, so stale values never pass
  always @(posedge ref_clk)
    for (int i = 0; i < NCONV; i++)
      cmp_bit[i] <= powered[i] ? level[i] : ~cmp_bit[i];

  // bench fires only while converter idle
  always @(posedge ref_clk)
  begin
    tmr0_ovf <= fire && fire_sel == TS_T0;
    tmr1_ovf <= fire && fire_sel == TS_T1;
    tmr2_match <= fire && fire_sel == TS_T2;
    if (fire && fire_sel == TS_RISE)
      ext_pin <= 1'b1;
    if (fire && fire_sel == TS_FALL)
      ext_pin <= 1'b0;
  end
endmodule : acc_far

// ===== tb/acc_top_tb.sv
module acc_top_tb
  import acc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                  ref_clk = 1'b0;
  logic                  rst_n = 1'b0;
  acc_apb_req_s          req = '0;
  logic [31:0]           prdata;
  logic [31:0]           rv;
  logic                  pready;
  logic                  pslverr;
  logic                  se;
  logic [NCONV-1:0]      cmp_bit;
  logic [NCONV-1:0]      level = 2'b01;
  logic [NCONV-1:0]      conv_power;
  logic [NCONV-1:0]      ch_connect;
  logic [NCONV-1:0]      sample_go;
  logic [NCONV-1:0][4:0] ch_route;
  logic                  sleep_req = 1'b0;
  logic                  fire = 1'b0;
  logic [2:0]            fsel = '0;
  logic                  t0;
  logic                  t1;
  logic                  t2;
  logic                  xpin;
  logic                  wake;
  int                    errors = 0;
  int                    compares = 0;

  always #50 ref_clk = ~ref_clk;

  acc_top uut (.ref_clk, .rst_n, .apb_req(req), .prdata, .pready, .pslverr, .cmp_bit,
    .sleep_req, .tmr0_ovf(t0), .tmr1_ovf(t1), .tmr2_match(t2), .external_trigger_pin(xpin),
    .conv_power, .ch_connect, .ch_route, .sample_go, .wake);

  acc_far far (.ref_clk, .level, .powered(conv_power), .fire_sel(fsel), .fire, .cmp_bit,
    .tmr0_ovf(t0), .tmr1_ovf(t1), .tmr2_match(t2), .ext_pin(xpin));

  task automatic close_out;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo;
    errors++;
    close_out();
  endtask : tmo

  // Setup, then access held until pready seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk) req <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk) req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
      tmo();
    rv = prdata;
    se = pslverr;
    req <= '0;
    #1;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask : rd

  task automatic wait_idle(input logic [7:0] a);
    for (int n = 0; n < 60; n++)
    begin
      apb(1'b0, a, 32'h0);
      if (rv[B_GO] === 1'b0)
        break;
    end
    if (rv[B_GO] !== 1'b0)
      tmo();
  endtask : wait_idle

  task automatic t_reset;
    for (int i = 0; i < 9; i++)
      rd(8'(4 * i), 32'h0);
    apb(1'b0, 8'h24, 32'h0);
    chk(se, 1);
    chk(conv_power, 0);
  endtask : t_reset

  task automatic t_single;
    wr(A_CTL_A, 32'h1);
    chk(conv_power, 1);
    wr(A_CTL_A, 32'h3);
    rd(A_CTL_A, 32'h3);
    wait_idle(A_CTL_A);
    rd(A_STAT, 32'h1);
    rd(A_RES, 32'h3FF);
    rd(8'h18, 32'h0);
    wr(A_STAT, 32'h1);
    wr(A_CTL_B, 32'h3);
    rd(A_CTL_B, 32'h1);
  endtask : t_single

  task automatic t_abort;
    level <= 2'b10;
    wr(A_CTL_A, 32'h3);
    repeat (6) @(posedge ref_clk);
    wr(A_CTL_A, 32'h1);
    rd(A_RES, 32'h0);
    rd(A_STAT, 32'h0);
  endtask : t_abort

  task automatic t_sync;
    level <= 2'b01;
    wr(A_COM, 32'h1);
    rd(A_CTL_B, 32'h3);
    wait_idle(A_CTL_A);
    wait_idle(A_CTL_B);
    rd(A_COM, 32'h0);
    rd(A_STAT, 32'h3);
    rd(A_RES, 32'h3FF);
    rd(8'h1C, 32'h0);
    wr(A_STAT, 32'h3);
    wr(A_COM, 32'h1);
    wr(A_COM, 32'h0);
    rd(A_CTL_A, 32'h1);
    rd(A_CTL_B, 32'h1);
    rd(A_STAT, 32'h0);
  endtask : t_sync

  task automatic t_double;
    level <= 2'b11;
    wr(A_COM, 32'h2);
    wr(A_CTL_B, 32'h3);
    wait_idle(A_CTL_B);
    rd(8'h1C, 32'h3FF);
    rd(8'h20, 32'h3FF);
    wr(A_COM, 32'h0);
    wr(A_STAT, 32'h3);
  endtask : t_double

  task automatic t_trig;
    logic [2:0] codes [6] = '{TS_T0, TS_T1, TS_T2, TS_RISE, TS_FALL, TS_NONE};
    for (int i = 0; i < 6; i++)
    begin
      wr(A_TRIG, {25'h0, codes[i], 4'h0});
      rd(A_TRIG, {25'h0, codes[i], 4'h0});
      @(posedge ref_clk) fsel <= (i == 5) ? TS_T0 : codes[i];
      fire <= 1'b1;
      @(posedge ref_clk) fire <= 1'b0;
      for (int n = 0; n < 12 && sample_go[0] !== 1'b1; n++)
        @(posedge ref_clk);
      chk(sample_go[0], i < 5);
      wait_idle(A_CTL_A);
    end
  endtask : t_trig

  task automatic t_chan;
    wr(A_CTL_B, 32'h75);
    chk(ch_route[1], 5'h1D);
    chk(ch_connect[1], 1);
    wr(A_CTL_B, 32'h0D);
    chk(ch_connect[1], 0);
    wr(A_CTL_B, 32'h51);
    chk(ch_connect[1], 1);
    wr(A_CTL_B, 32'h50);
    chk(ch_connect[1], 0);
  endtask : t_chan

  task automatic t_sleep;
    wr(A_CTL_A, 32'h3);
    @(posedge ref_clk) sleep_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(conv_power[0], 0);
    rd(A_CTL_A, 32'h1);
    @(posedge ref_clk) sleep_req <= 1'b0;
    wr(A_COM, 32'hC);
    wr(A_CTL_A, 32'h3);
    chk(sample_go[0], 0);
    @(posedge ref_clk) sleep_req <= 1'b1;
    #1;
    chk(sample_go[0], 1);
    for (int n = 0; n < 80 && wake !== 1'b1; n++)
      @(posedge ref_clk);
    chk(wake, 1);
    wr(A_COM, 32'h4);
    wr(A_CTL_A, 32'h3);
    wait_idle(A_CTL_A);
    chk(conv_power[0], 0);
    rd(A_CTL_A, 32'h1);
    sleep_req <= 1'b0;
    wr(A_COM, 32'h0);
  endtask : t_sleep

  task automatic t_reset2;
    wr(A_CTL_A, 32'h3);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(conv_power, 0);
    rd(A_CTL_A, 32'h0);
  endtask : t_reset2

  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_single();
    t_abort();
    t_sync();
    t_double();
    t_trig();
    t_chan();
    t_sleep();
    t_reset2();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    tmo();
  end
endmodule : acc_top_tb
